// File: asc_ctrl.sv
// Controller that drives an asynchronous 32768 x 8 static memory through its pins.
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_ctrl #(
    // Access lengths in clock cycles.
    parameter logic [3:0] READ_CYC = 4'(`ASC_READ_CYCLES),
    parameter logic [3:0] WRITE_CYC = 4'(`ASC_WRITE_CYCLES),
    // Bus turnaround and power-down recovery in clock cycles.
    parameter logic [3:0] FLOAT_CYC = 4'(`ASC_FLOAT_CYCLES),
    parameter logic [3:0] RECOVER_CYC = 4'(`ASC_RECOVER_CYCLES)
) (
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // User request side.
    input wire logic REQ_VALID,
    input asc_pkg::asc_req_type REQ,
    output logic REQ_READY,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    // Power-down control.
    input wire logic PWR_DOWN,
    // Memory pins.
    output logic [14:0] MEM_ADDR,
    output logic MEM_SEL_B,
    output logic MEM_WE_B,
    output logic MEM_OE_B,
    input wire logic [7:0] MEM_DQ_IN,
    output logic [7:0] MEM_DQ_OUT,
    output logic MEM_DQ_OE_B
);
    import asc_pkg::*;
    // A count of zero would wrap the down-counter, so it is treated as one cycle.
    localparam logic [3:0] WRITE_LEN = (WRITE_CYC == 4'h0) ? 4'h1 : WRITE_CYC;
    localparam logic [3:0] FLOAT_LEN = (FLOAT_CYC == 4'h0) ? 4'h1 : FLOAT_CYC;
    localparam logic [3:0] RECOVER_LEN = (RECOVER_CYC == 4'h0) ? 4'h1 : RECOVER_CYC;

    // Sequencer state.
    asc_state_type state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;

    // Registered memory pins.
    logic [14:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic sel_b_reg, sel_b_next;
    logic we_b_reg, we_b_next;
    logic oe_b_reg, oe_b_next;
    logic dq_oe_b_reg, dq_oe_b_next;

    // Answer to the user side.
    logic ready_reg, ready_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;

    // Synchronisers for the pin inputs.
    logic [7:0] dq_s1_reg, dq_s1_next, dq_s2_reg, dq_s2_next;
    logic pd_s1_reg, pd_s1_next, pd_s2_reg, pd_s2_next;

    // Pin inputs pass two flip-flops before use.
    // The data lane is only read late in a read, after it has settled.
    always_comb begin
        dq_s1_next = MEM_DQ_IN;
        dq_s2_next = dq_s1_reg;
        pd_s1_next = PWR_DOWN;
        pd_s2_next = pd_s1_reg;
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            dq_s1_reg <= 8'h00;
            dq_s2_reg <= 8'h00;
            pd_s1_reg <= 1'b0;
            pd_s2_reg <= 1'b0;
        end else begin
            dq_s1_reg <= dq_s1_next;
            dq_s2_reg <= dq_s2_next;
            pd_s1_reg <= pd_s1_next;
            pd_s2_reg <= pd_s2_next;
        end
    end

    // Sequencer: one access at a time, strobes change only on clock edges.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        sel_b_next = sel_b_reg;
        we_b_next = we_b_reg;
        oe_b_next = oe_b_reg;
        dq_oe_b_next = dq_oe_b_reg;
        ready_next = 1'b0;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        case (state_reg)
            ASC_IDLE: begin
                // A request seen with ready high is always honoured, or the requester
                // would believe it taken; power-down then follows that one access.
                if (REQ_VALID && ready_reg) begin
                    addr_next = REQ.addr; // [RULE3]
                    wdata_next = REQ.wdata;
                    sel_b_next = 1'b0;
                    if (REQ.write) begin
                        // Output enable stays high, so the memory never drives.
                        we_b_next = 1'b0; // [RULE20]
                        oe_b_next = 1'b1;
                        dq_oe_b_next = 1'b0;
                        cnt_next = WRITE_LEN;
                        state_next = ASC_WRITE;
                    end else begin
                        we_b_next = 1'b1;
                        oe_b_next = 1'b0;
                        dq_oe_b_next = 1'b1; // [RULE20]
                        cnt_next = READ_CYC + 4'h2;
                        state_next = ASC_READ;
                    end
                end else if (pd_s2_reg) begin
                    // PWR_DOWN must lead the supply fall by the synchroniser and one access.
                    sel_b_next = 1'b1; // [RULE18]
                    state_next = ASC_POWER;
                end else begin
                    ready_next = 1'b1;
                end
            end
            ASC_READ: begin
                // Two extra cycles cover the data synchroniser.
                if (cnt_reg == 4'h1) begin
                    rdata_next = dq_s2_reg; // [RULE11] [RULE12]
                    rvalid_next = 1'b1;
                    sel_b_next = 1'b1;
                    oe_b_next = 1'b1;
                    cnt_next = FLOAT_LEN;
                    state_next = ASC_FLOAT;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            ASC_WRITE: begin
                // Address and select held for the setup time before the ending edge.
                if (cnt_reg == 4'h1) begin
                    // Select rises with write enable, so both end the overlap on one edge.
                    we_b_next = 1'b1; // [RULE16] [RULE17]
                    sel_b_next = 1'b1;
                    cnt_next = 4'h1;
                    state_next = ASC_FLOAT;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            ASC_FLOAT: begin
                // Data held one cycle past the ending edge, or memory given time to float.
                dq_oe_b_next = 1'b1;
                if (cnt_reg == 4'h1) begin
                    state_next = ASC_IDLE;
                    // No new offer once power-down is pending, so it waits one access at most.
                    ready_next = !pd_s2_reg; // [RULE18]
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            ASC_POWER: begin
                // Select stays high; the supply may be removed while here.
                sel_b_next = 1'b1;
                if (!pd_s2_reg) begin
                    cnt_next = RECOVER_LEN;
                    state_next = ASC_RECOVER;
                end
            end
            ASC_RECOVER: begin
                // Select is held high a full read cycle before the first new access.
                if (cnt_reg == 4'h1) begin
                    state_next = ASC_IDLE; // [RULE19]
                    ready_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default: begin
                state_next = ASC_IDLE;
            end
        endcase
    end

    // Reset parks every strobe high, so the memory is deselected and the lane free.
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= ASC_IDLE;
            cnt_reg <= 4'h0;
            addr_reg <= 15'h0000;
            wdata_reg <= 8'h00;
            sel_b_reg <= 1'b1;
            we_b_reg <= 1'b1;
            oe_b_reg <= 1'b1;
            dq_oe_b_reg <= 1'b1;
            ready_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            sel_b_reg <= sel_b_next;
            we_b_reg <= we_b_next;
            oe_b_reg <= oe_b_next;
            dq_oe_b_reg <= dq_oe_b_next;
            ready_reg <= ready_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // Every pin and answer comes straight from a register, so no glitch reaches the memory.
    assign REQ_READY = ready_reg;
    assign RD_DATA = rdata_reg;
    assign RD_VALID = rvalid_reg;
    assign MEM_ADDR = addr_reg;
    assign MEM_SEL_B = sel_b_reg;
    assign MEM_WE_B = we_b_reg;
    assign MEM_OE_B = oe_b_reg;
    assign MEM_DQ_OUT = wdata_reg;
    assign MEM_DQ_OE_B = dq_oe_b_reg;
endmodule : asc_ctrl

// File: asc_regs.svh
// Timing constants for the asynchronous static memory controller.
// Summary of operation
// [RULE1] Memory has 32768 byte locations, fifteen-bit address, one shared byte lane.
// [RULE2] A write happens only while write enable and chip select are both low.
// [RULE3] Controller sets the address before a write and holds it throughout; the code sets it on the edge that select and write enable fall.
// [RULE4] Memory captures data at the rising edge ending the write overlap.
// [RULE5] Output enable high floats the memory data pins.
// [RULE6] Select low, write high, output enable low makes the memory drive data.
// [RULE7] Deselected memory ignores strobes and floats its data pins.
// [RULE8] Write enable falling with or before select keeps memory outputs off.
// [RULE9] Memory floats pins within 20 or 25 ns after write enable falls.
// [RULE10] Memory drives no sooner than 5 ns after write enable rises.
// [RULE11] Read data valid within 55 or 70 ns after select falls.
// [RULE12] Read data valid within 30 or 35 ns after output enable falls.
// [RULE13] Old data stays valid at least 10 ns after address change.
// [RULE14] Memory floats within 20 or 25 ns after select rises.
// [RULE15] Memory floats within 20 or 25 ns after output enable rises.
// [RULE16] Controller holds address at least 50 or 65 ns before write enable rises.
// [RULE17] Controller holds select low at least 50 or 65 ns before write end.
// [RULE18] Controller raises select no later than supply begins to fall.
// [RULE19] After power-down, select stays high one read cycle period first.
// [RULE20] Controller stops driving data whenever the memory may drive it.
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_CLK_PERIOD_NS 25
`define ASC_READ_CYCLE_NS 70
`define ASC_ACCESS_SEL_NS 70
`define ASC_ACCESS_OE_NS 35
`define ASC_DISABLE_NS 25
`define ASC_WRITE_SETUP_NS 65
`define ASC_DATA_SETUP_NS 30
`define ASC_CYC_UP(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_READ_CYCLES `ASC_CYC_UP(`ASC_ACCESS_SEL_NS)
`define ASC_WRITE_CYCLES `ASC_CYC_UP(`ASC_WRITE_SETUP_NS)
`define ASC_FLOAT_CYCLES `ASC_CYC_UP(`ASC_DISABLE_NS)
`define ASC_RECOVER_CYCLES `ASC_CYC_UP(`ASC_READ_CYCLE_NS)
`endif

// File: asc_pkg.sv
// Types shared by the static memory controller.
package asc_pkg;
    typedef struct packed {
        logic write;
        logic [14:0] addr;
        logic [7:0] wdata;
    } asc_req_type;
    typedef enum logic [2:0] {ASC_IDLE, ASC_READ, ASC_WRITE, ASC_FLOAT, ASC_POWER,
        ASC_RECOVER} asc_state_type;
endpackage : asc_pkg

// File: asc_ctrl_props.sv
// Checker for the static memory controller pins.
`timescale 1ns/1ps
module asc_ctrl_props (
    // Clock, reset and user side.
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic REQ_VALID,
    input asc_pkg::asc_req_type REQ,
    input wire logic REQ_READY,
    input wire logic RD_VALID,
    input wire logic PWR_DOWN,
    // Memory pins.
    input wire logic [14:0] MEM_ADDR,
    input wire logic MEM_SEL_B,
    input wire logic MEM_WE_B,
    input wire logic MEM_OE_B,
    input wire logic MEM_DQ_OE_B
);
    import asc_pkg::*;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);
    wire take = REQ_VALID && REQ_READY;
    a_addr_hold: assert property (
        !MEM_SEL_B && !MEM_WE_B |=> MEM_WE_B || $stable(MEM_ADDR)) else $error("addr moved");
    a_write_width: assert property (
        $fell(MEM_WE_B) |-> (!MEM_WE_B && !MEM_SEL_B) [*3]) else $error("write too short");
    a_no_clash: assert property (
        !MEM_DQ_OE_B |-> MEM_OE_B && $past(MEM_OE_B)) else $error("bus contention");
    a_down_sel: assert property (
        PWR_DOWN [*8] ##1 PWR_DOWN |-> MEM_SEL_B) else $error("selected in power-down");
    a_down_recover: assert property (
        PWR_DOWN [*8] ##1 !PWR_DOWN |-> (MEM_SEL_B && !REQ_READY) [*4]) else $error("early access");
    a_read_answer: assert property (
        take && !REQ.write |-> ##[6:9] RD_VALID) else $error("no read answer");
    a_write_mode: assert property (
        take && REQ.write |-> ##[1:2] !MEM_WE_B && !MEM_SEL_B && MEM_OE_B) else $error("no write");
    a_write_release: assert property (
        $rose(MEM_WE_B) |=> MEM_DQ_OE_B) else $error("data not released");
endmodule : asc_ctrl_props

// File: asc_mem_model.sv
// Behavioural model of the 32768 x 8 asynchronous static memory.
`timescale 1ns/1ps
module asc_mem_model (
    // Pins from the controller.
    input wire logic [14:0] addr,
    input wire logic sel_b,
    input wire logic we_b,
    input wire logic oe_b,
    input wire logic [7:0] din,
    input wire logic din_oe_b,
    // Resolved data lane.
    output logic [7:0] dq
);
    logic [7:0] mem [0:32767];
    logic [7:0] q = 8'h00;
    logic [7:0] idle_pat = 8'h00;
    logic drive = 1'b0;
    wire wr = !sel_b && !we_b;
    wire rd = !sel_b && we_b && !oe_b;
    // A released lane wanders so that stale data is never mistaken for a read.
    always #25 idle_pat = idle_pat + 8'h35;
    always @(negedge wr) mem[addr] = dq;
    always @(rd) drive <= #((rd === 1'b1) ? 5 : 20) (rd === 1'b1);
    always @(rd or addr) begin
        q <= #10 ~q;
        q <= #70 mem[addr];
    end
    assign dq = !din_oe_b ? din : drive ? q : idle_pat;
endmodule : asc_mem_model

// File: asc_tb.sv
// Self-checking bench for the static memory controller.
`timescale 1ns/1ps
module tb;
    import asc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic pwr_down = 1'b0;
    asc_req_type req = '0;
    logic req_ready, rd_valid, sel_b, we_b, oe_b, dq_oe_b;
    logic [7:0] rd_data, dq_out, dq;
    logic [14:0] addr;
    int bad_count = 0;
    int comparisons = 0;
    always #12.5 sys_clk = ~sys_clk;
    asc_ctrl dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .REQ_VALID(req_valid), .REQ(req),
        .REQ_READY(req_ready), .RD_DATA(rd_data), .RD_VALID(rd_valid), .PWR_DOWN(pwr_down),
        .MEM_ADDR(addr), .MEM_SEL_B(sel_b), .MEM_WE_B(we_b), .MEM_OE_B(oe_b),
        .MEM_DQ_IN(dq), .MEM_DQ_OUT(dq_out), .MEM_DQ_OE_B(dq_oe_b));
    asc_mem_model mem (.addr(addr), .sel_b(sel_b), .we_b(we_b), .oe_b(oe_b), .din(dq_out),
        .din_oe_b(dq_oe_b), .dq(dq));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d, output int n);
        int m;
        n = 0;
        m = 0;
        req_valid <= 1'b1;
        req <= '{w, a, d};
        @(negedge sys_clk);
        while (req_ready !== 1'b1 && n < 40) begin
            n++;
            @(negedge sys_clk);
        end
        check("request ready", 8'h01, {7'h0, req_ready});
        @(posedge sys_clk);
        req_valid <= 1'b0;
        if (!w) begin
            do @(negedge sys_clk); while (rd_valid !== 1'b1 && ++m < 20);
            check("read valid", 8'h01, {7'h0, rd_valid});
            check("read data", d, rd_data);
        end
        @(posedge sys_clk);
    endtask : xfer
    task automatic test_data();
        logic [14:0] a [4] = '{15'h0000, 15'h7fff, 15'h1234, 15'h4cb3};
        int n;
        foreach (a[i]) xfer(1'b1, a[i], a[i][7:0] ^ 8'h5a, n);
        foreach (a[i]) xfer(1'b0, a[i], a[i][7:0] ^ 8'h5a, n);
        $display("test_data done");
    endtask : test_data
    task automatic test_power();
        int n;
        pwr_down <= 1'b1;
        repeat (2) @(posedge sys_clk);
        // This read is offered on the very edge at which power-down is first seen.
        xfer(1'b0, 15'h1234, 8'h6e, n);
        repeat (10) @(posedge sys_clk);
        check("select", 8'h01, {7'h0, sel_b});
        check("ready in power-down", 8'h00, {7'h0, req_ready});
        fork
            begin
                repeat (6) @(posedge sys_clk);
                pwr_down <= 1'b0;
            end
        join_none
        xfer(1'b0, 15'h7fff, 8'ha5, n);
        check("recovery wait", 8'h01, {7'h0, n >= 9});
        $display("test_power done");
    endtask : test_power
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (5) @(posedge sys_clk);
        check("idle strobes", 8'h0f, {4'h0, sel_b, we_b, oe_b, dq_oe_b});
        rst_b <= 1'b1;
        test_data();
        test_power();
        finish_test();
    end
    initial begin
        #(2000 * 25);
        bad_count++;
        finish_test();
    end
endmodule : tb
bind asc_ctrl asc_ctrl_props u_props (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .REQ_READY(REQ_READY), .RD_VALID(RD_VALID), .PWR_DOWN(PWR_DOWN),
    .MEM_ADDR(MEM_ADDR), .MEM_SEL_B(MEM_SEL_B), .MEM_WE_B(MEM_WE_B), .MEM_OE_B(MEM_OE_B),
    .MEM_DQ_OE_B(MEM_DQ_OE_B));
